// file: rtl/rpu_defines.svh
// Purpose: constants for the region protection unit
// Assumes: 32-bit AXI4-Lite register bus
// Notes:   offsets are byte addresses
`ifndef RPU_DEFINES_SVH
`define RPU_DEFINES_SVH
`define RPU_NREG        8
// ======================================================
// register offsets
`define RPU_OFF_CTRL    12'h000
`define RPU_OFF_FSTAT   12'h004
`define RPU_OFF_FADDR   12'h008
`define RPU_OFF_RBASE   12'h100
`define RPU_OFF_RLIM    12'h140
`define RPU_OFF_RATTR   12'h180
`define RPU_REG_AMASK   12'hFC0
`define RPU_REG_ASHIFT  2
// ======================================================
// attribute field layout
`define RPU_ATTR_EN     0
`define RPU_ATTR_XN     1
`define RPU_AP_LO       2
`define RPU_AP_HI       4
// ======================================================
// access permission encodings
`define RPU_AP_NONE     3'h0
`define RPU_AP_PRW      3'h1
`define RPU_AP_PRW_URO  3'h2
`define RPU_AP_FULL     3'h3
`define RPU_AP_PRO      3'h5
`define RPU_AP_RO       3'h6
// ======================================================
// reset values and AXI response codes
`define RPU_ATTR_RST    5'h00
`define RPU_BASE_RST    32'h0000_0000
`define RPU_LIM_RST     32'h0000_0000
`define RPU_CTRL_RST    1'b0
`define RPU_RESP_OK     2'b00
`define RPU_RESP_SLV    2'b10
`endif

// file: rtl/rpu_pkg.sv
// Purpose: types for the region protection unit
// Assumes: nothing
// Notes:   none
package rpu_pkg;
   typedef enum logic [1:0] {RPU_OP_READ, RPU_OP_WRITE, RPU_OP_EXEC} rpu_op_e;
   typedef enum logic {RPU_LVL_USER, RPU_LVL_PRIV} rpu_lvl_e;
endpackage

// file: rtl/rpu_chk_if.sv
// Purpose: carries one access between top and checker
// Assumes: single clock
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface rpu_chk_if;
   import rpu_pkg::*;
   logic [31:0] addr;
   rpu_op_e     op;
   rpu_lvl_e    lvl;
   logic        allow;
   modport top (output addr, output op, output lvl, input allow);
   modport chk (input addr, input op, input lvl, output allow);
endinterface
`default_nettype wire

// file: rtl/rpu_region_check.sv
// Purpose: combinational permission decision for one access
// Assumes: region tables are stable registers
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
`include "rpu_defines.svh"
module rpu_region_check #(
   parameter int NREG = `RPU_NREG
) (
   rpu_chk_if.chk          acc,
   input  wire logic [31:0] base [NREG],
   input  wire logic [31:0] lim  [NREG],
   input  wire logic [4:0]  attr [NREG],
   input  wire logic        prot_en
);
   import rpu_pkg::*;
   logic [NREG-1:0] hit;
   logic [2:0]      ap;
   logic            xn;
   logic            found;
   logic            priv;
   logic            rd;
   logic            wr;
   logic            pr;
   logic            pw;
   logic            ur;
   logic            uw;

   // ======================================================
   // region match, one per region
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_hit
         assign hit[gi] = attr[gi][`RPU_ATTR_EN] &&
                          acc.addr >= base[gi] && acc.addr <= lim[gi];
      end
   endgenerate

   // ======================================================
   // decision
   always_comb begin
      ap    = `RPU_AP_NONE;
      xn    = 1'b1;
      found = 1'b0;
      // RULE4: highest region wins
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            ap    = attr[i][`RPU_AP_HI:`RPU_AP_LO];
            xn    = attr[i][`RPU_ATTR_XN];
            found = 1'b1;
         end
      end
      priv = (acc.lvl == RPU_LVL_PRIV);
      // RULE15: classify each operation
      rd = (acc.op == RPU_OP_READ) || (acc.op == RPU_OP_EXEC);
      wr = (acc.op == RPU_OP_WRITE);
      pr = 1'b0;
      pw = 1'b0;
      ur = 1'b0;
      uw = 1'b0;
      case (ap)
         // RULE8: no access at all
         `RPU_AP_NONE: begin
         end
         // RULE9: privileged only
         `RPU_AP_PRW: begin
            pr = 1'b1;
            pw = 1'b1;
         end
         // RULE10: user read only
         `RPU_AP_PRW_URO: begin
            pr = 1'b1;
            pw = 1'b1;
            ur = 1'b1;
         end
         // RULE20: full access
         `RPU_AP_FULL: begin
            pr = 1'b1;
            pw = 1'b1;
            ur = 1'b1;
            uw = 1'b1;
         end
         // RULE11: privileged read only
         `RPU_AP_PRO: begin
            pr = 1'b1;
         end
         // RULE12: read only both
         `RPU_AP_RO: begin
            pr = 1'b1;
            ur = 1'b1;
         end
         default: begin
         end
      endcase
      if (!prot_en) begin
         acc.allow = 1'b1;
      end else if (!found) begin
         // RULE3: background privileged only
         acc.allow = priv;
      end else if (acc.op == RPU_OP_EXEC && xn) begin
         // RULE7: fetch forbidden
         acc.allow = 1'b0;
      end else if (priv) begin
         // RULE1: privileged rights, RULE5: includes user regions
         acc.allow = (rd && pr) || (wr && pw);
      end else begin
         // RULE6: user refused in privileged regions
         acc.allow = (rd && ur) || (wr && uw);
      end
   end
endmodule
`default_nettype wire

// file: rtl/rpu_top.sv
// Summary of operation
// RULE1: two levels, privileged and user; each access checked by issuer level
// RULE2: up to eight programmable regions, each with own rights
// RULE3: privileged-only background region where no region matches
// RULE4: overlapping regions resolved by highest region number
// RULE5: privileged accesses allowed into user-accessible regions
// RULE6: user accesses refused in privileged-only regions
// RULE7: per-region fetch enable; forbidden fetches denied
// RULE8: no-access setting faults every access
// RULE9: privileged read/write, user none
// RULE10: privileged read/write, user read only; user writes fault
// RULE11: privileged read only, user none
// RULE12: read only at both levels
// RULE13: checked in hardware each access; denied access has no effect
// RULE14: every access checked, no bypass path
// RULE15: read, write, execute classified separately
// RULE16: software programs boundaries and attributes
// RULE17: defined reset defaults, reprogrammable at run time
// RULE18: only privileged writes may change attributes
// RULE19: fault reported with address and access type
// RULE20: full access setting never faults reads or writes
//
// Purpose: region protection between core and memory
// Assumes: aclk 250 MHz, aresetn synchronous active low
// Notes:   core access request passes to memory only when allowed
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rpu_defines.svh"
module rpu_top #(
   parameter int NREG = `RPU_NREG
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // axi4-lite slave
   input  wire logic [11:0]    s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [2:0]     s_axi_awprot,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [11:0]    s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   input  wire logic [2:0]     s_axi_arprot,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   // core access side
   input  wire logic           core_req,
   input  wire logic [31:0]    core_addr,
   input  wire rpu_pkg::rpu_op_e  core_op,
   input  wire rpu_pkg::rpu_lvl_e core_lvl,
   input  wire logic [31:0]    core_wdata,
   output logic                core_fault,
   output logic [31:0]         core_fault_addr,
   output rpu_pkg::rpu_op_e    core_fault_op,
   output logic [31:0]         core_rdata,
   input  wire logic [31:0]    mem_rdata,
   output logic                mem_req,
   output logic                mem_we,
   output logic [31:0]         mem_addr,
   output logic [31:0]         mem_wdata
);
   import rpu_pkg::*;

   // ======================================================
   // state
   typedef struct packed {
      logic                  prot_en;
      logic [NREG-1:0][31:0] base;
      logic [NREG-1:0][31:0] lim;
      logic [NREG-1:0][4:0]  attr;
      logic                  aw_got;
      logic [11:0]           aw_addr;
      logic                  aw_priv;
      logic                  w_got;
      logic [31:0]           w_data;
      logic [3:0]            w_strb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic                  fault_sticky;
      logic [31:0]           faddr;
      rpu_op_e               fop;
      rpu_lvl_e              flvl;
   } rpu_state_s;

   rpu_state_s st_q;
   rpu_state_s st_d;

   logic [31:0] base_a [NREG];
   logic [31:0] lim_a  [NREG];
   logic [4:0]  attr_a [NREG];
   logic        allow;
   logic [11:0] waddr;
   logic [11:0] ridx_off;
   int          widx;
   int          ridx;

   rpu_chk_if chk ();

   // RULE2: per-region tables
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_tab
         assign base_a[gi] = st_q.base[gi];
         assign lim_a[gi]  = st_q.lim[gi];
         assign attr_a[gi] = st_q.attr[gi];
      end
   endgenerate

   // ======================================================
   // access check
   // RULE14: every core access goes through the checker
   assign chk.addr = core_addr;
   assign chk.op   = core_op;
   assign chk.lvl  = core_lvl;
   assign allow    = chk.allow;

   rpu_region_check #(
      .NREG (NREG)
   ) u_check (
      .acc     (chk.chk),
      .base    (base_a),
      .lim     (lim_a),
      .attr    (attr_a),
      .prot_en (st_q.prot_en)
   );

   // RULE13: denied accesses never reach memory
   assign mem_req    = core_req && allow;
   assign mem_we     = core_req && allow && (core_op == RPU_OP_WRITE);
   assign mem_addr   = core_addr;
   assign mem_wdata  = core_wdata;
   assign core_rdata = (core_req && allow) ? mem_rdata : 32'h0000_0000;
   // RULE19: fault flagged in the access cycle, address and type one cycle later
   assign core_fault      = core_req && !allow;
   assign core_fault_addr = st_q.faddr;
   assign core_fault_op   = st_q.fop;

   // ======================================================
   // axi outputs
   assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;

   assign waddr    = st_q.aw_addr & `RPU_REG_AMASK;
   assign widx     = int'(st_q.aw_addr[5:`RPU_REG_ASHIFT]);
   assign ridx_off = s_axi_araddr & `RPU_REG_AMASK;
   assign ridx     = int'(s_axi_araddr[5:`RPU_REG_ASHIFT]);

   // ======================================================
   // next state
   always_comb begin
      st_d = st_q;
      // capture write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.aw_got  = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
         st_d.aw_priv = s_axi_awprot[0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.w_got  = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.aw_got && st_q.w_got) begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = `RPU_RESP_OK;
         // RULE18: unprivileged writes refused
         if (!st_q.aw_priv) begin
            st_d.bresp = `RPU_RESP_SLV;
         end else if (st_q.aw_addr == `RPU_OFF_CTRL) begin
            // RULE17: run-time reprogramming
            if (st_q.w_strb[0]) begin
               st_d.prot_en = st_q.w_data[0];
            end
         end else if (st_q.aw_addr == `RPU_OFF_FSTAT) begin
            if (st_q.w_strb[0] && st_q.w_data[0]) begin
               st_d.fault_sticky = 1'b0;
            end
         end else if (widx < NREG && waddr == `RPU_OFF_RBASE) begin
            for (int b = 0; b < 4; b++) begin
               if (st_q.w_strb[b]) begin
                  st_d.base[widx][b*8 +: 8] = st_q.w_data[b*8 +: 8];
               end
            end
         end else if (widx < NREG && waddr == `RPU_OFF_RLIM) begin
            for (int b = 0; b < 4; b++) begin
               if (st_q.w_strb[b]) begin
                  st_d.lim[widx][b*8 +: 8] = st_q.w_data[b*8 +: 8];
               end
            end
         end else if (widx < NREG && waddr == `RPU_OFF_RATTR) begin
            if (st_q.w_strb[0]) begin
               st_d.attr[widx] = st_q.w_data[4:0];
            end
         end else begin
            st_d.bresp = `RPU_RESP_SLV;
         end
      end
      // read channel
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = `RPU_RESP_OK;
         st_d.rdata  = 32'h0000_0000;
         if (s_axi_araddr == `RPU_OFF_CTRL) begin
            st_d.rdata[0] = st_q.prot_en;
         end else if (s_axi_araddr == `RPU_OFF_FSTAT) begin
            st_d.rdata = {28'h000_0000, st_q.flvl, st_q.fop, st_q.fault_sticky};
         end else if (s_axi_araddr == `RPU_OFF_FADDR) begin
            st_d.rdata = st_q.faddr;
         end else if (ridx < NREG && ridx_off == `RPU_OFF_RBASE) begin
            st_d.rdata = st_q.base[ridx];
         end else if (ridx < NREG && ridx_off == `RPU_OFF_RLIM) begin
            st_d.rdata = st_q.lim[ridx];
         end else if (ridx < NREG && ridx_off == `RPU_OFF_RATTR) begin
            st_d.rdata = {27'h000_0000, st_q.attr[ridx]};
         end else begin
            st_d.rresp = `RPU_RESP_SLV;
         end
      end
      // RULE19: record fault, set wins over clear
      if (core_fault) begin
         st_d.fault_sticky = 1'b1;
         st_d.faddr        = core_addr;
         st_d.fop          = core_op;
         st_d.flvl         = core_lvl;
      end
   end

   // ======================================================
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // RULE17: defined defaults
         st_q              <= '0;
         st_q.prot_en      <= `RPU_CTRL_RST;
         for (int i = 0; i < NREG; i++) begin
            st_q.base[i] <= `RPU_BASE_RST;
            st_q.lim[i]  <= `RPU_LIM_RST;
            st_q.attr[i] <= `RPU_ATTR_RST;
         end
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

// file: tb/rpu_top_asserts.sv
// Purpose: concurrent checks on the protection top ports
// Assumes: one clock domain, reset active low
// Notes:   bound into rpu_top
`timescale 1ns/10ps
`default_nettype none
module rpu_top_asserts (
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             core_req,
   input wire logic [31:0]      core_addr,
   input wire rpu_pkg::rpu_op_e core_op,
   input wire logic [31:0]      core_wdata,
   input wire logic             core_fault,
   input wire logic [31:0]      core_fault_addr,
   input wire rpu_pkg::rpu_op_e core_fault_op,
   input wire logic [31:0]      core_rdata,
   input wire logic [31:0]      mem_rdata,
   input wire logic             mem_req,
   input wire logic             mem_we,
   input wire logic [31:0]      mem_addr,
   input wire logic [31:0]      mem_wdata
);
   import rpu_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========
   // access outcome
   chk_one_outcome: assert property (core_req |-> mem_req != core_fault)
      else $error("access neither passed nor faulted");
   chk_idle_quiet: assert property (!core_req |-> !mem_req && !core_fault)
      else $error("memory or fault without request");
   chk_pass_thru: assert property (mem_req |-> mem_addr == core_addr
      && mem_we == (core_op == RPU_OP_WRITE))
      else $error("memory address or kind wrong");
   chk_wdata_thru: assert property (mem_req && mem_we |-> mem_wdata == core_wdata)
      else $error("write data not passed");
   chk_fault_rdata: assert property (core_fault |-> core_rdata == 32'h0000_0000)
      else $error("denied access returned data");
   chk_read_rdata: assert property (mem_req && !mem_we |-> core_rdata == mem_rdata)
      else $error("read data not passed");
   chk_fault_addr: assert property (core_fault |=> core_fault_addr == $past(core_addr))
      else $error("fault address wrong");
   chk_fault_op: assert property (core_fault |=> core_fault_op == $past(core_op))
      else $error("fault access kind wrong");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule
bind rpu_top rpu_top_asserts u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .core_req, .core_addr, .core_op, .core_wdata, .core_fault,
   .core_fault_addr, .core_fault_op, .core_rdata, .mem_rdata, .mem_req, .mem_we,
   .mem_addr, .mem_wdata);
`default_nettype wire

// file: tb/rpu_mem_model.sv
// Purpose: memory behind the protection unit
// Assumes: sixteen words, indexed by address bits 5:2
// Notes:   read data toggles when not selected
`timescale 1ns/10ps
`default_nettype none
module rpu_mem_model (
   input  wire logic        aclk,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic [31:0]      mem_rdata
);
   logic [31:0] m [16];
   logic [31:0] last_q;
   initial foreach (m[i]) m[i] = 32'h0000_0000;
   initial last_q = 32'h0000_0000;
   assign mem_rdata = mem_req ? m[mem_addr[5:2]] : ~last_q;
   always @(posedge aclk) begin
      last_q <= mem_rdata;
      if (mem_req && mem_we) m[mem_addr[5:2]] <= mem_wdata;
   end
endmodule
`default_nettype wire

// file: tb/rpu_top_tb.sv
// Purpose: directed bench for the protection top
// Assumes: 250 MHz clock, synchronous reset
// Notes:   expected values from a shadow memory
`timescale 1ns/10ps
`default_nettype none
`include "rpu_defines.svh"
module rpu_top_tb;
   import rpu_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, core_req, core_fault, mem_req, mem_we;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_wdata, s_axi_rdata, core_addr, core_wdata, core_fault_addr;
   logic [31:0] core_rdata, mem_rdata, mem_addr, mem_wdata;
   logic [31:0] sh [16];
   rpu_op_e     core_op, core_fault_op;
   rpu_lvl_e    core_lvl;
   int          n_errors = 0;
   int          n_compared = 0;
   rpu_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awprot, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_arprot, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .core_req, .core_addr, .core_op, .core_lvl, .core_wdata,
      .core_fault, .core_fault_addr, .core_fault_op, .core_rdata, .mem_rdata,
      .mem_req, .mem_we, .mem_addr, .mem_wdata);
   rpu_mem_model u_mem (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ==========
   // shared tasks
   task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task axi(input logic we, input logic [11:0] a, input logic [31:0] d, input logic p,
            input logic [1:0] er, input logic [31:0] ed);
      logic aw, w, ar, dn;
      logic [1:0] rs;
      logic [31:0] rv;
      int i;
      @(posedge aclk);
      if (we) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awprot <= {2'b00, p};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arprot <= {2'b00, p};
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      dn = 1'b0;
      i = 0;
      while (!dn && i < 64) begin
         #1;
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         ar = s_axi_arvalid && s_axi_arready;
         dn = we ? s_axi_bvalid : s_axi_rvalid;
         rs = we ? s_axi_bresp : s_axi_rresp;
         rv = s_axi_rdata;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (ar) s_axi_arvalid <= 1'b0;
         i++;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      ck("axi done", 32'h0000_0001, {31'd0, dn});
      ck("axi resp", {30'd0, er}, {30'd0, rs});
      if (!we) ck("axi rdata", ed, rv);
   endtask
   task acc(input logic [31:0] a, input rpu_op_e op, input rpu_lvl_e lv, input logic ok);
      @(posedge aclk);
      core_req <= 1'b1;
      core_addr <= a;
      core_op <= op;
      core_lvl <= lv;
      core_wdata <= a ^ 32'h5A5A_0000;
      #1;
      ck("core_fault", {31'd0, !ok}, {31'd0, core_fault});
      ck("mem_req", {31'd0, ok}, {31'd0, mem_req});
      if (op == RPU_OP_READ) ck("core_rdata", ok ? sh[a[5:2]] : 32'h0000_0000, core_rdata);
      if (ok && op == RPU_OP_WRITE) sh[a[5:2]] = a ^ 32'h5A5A_0000;
      @(posedge aclk);
      core_req <= 1'b0;
   endtask
   task region(input int n, input logic [31:0] b, input logic [31:0] l, input logic [4:0] at);
      axi(1'b1, 12'(`RPU_OFF_RBASE + 4 * n), b, 1'b1, `RPU_RESP_OK, 0);
      axi(1'b1, 12'(`RPU_OFF_RLIM + 4 * n), l, 1'b1, `RPU_RESP_OK, 0);
      axi(1'b1, 12'(`RPU_OFF_RATTR + 4 * n), {27'd0, at}, 1'b1, `RPU_RESP_OK, 0);
   endtask
   // ==========
   // scenarios
   task t_defaults;
      axi(1'b0, `RPU_OFF_CTRL, 0, 1'b1, `RPU_RESP_OK, 32'h0000_0000);
      axi(1'b0, `RPU_OFF_RATTR, 0, 1'b1, `RPU_RESP_OK, 32'h0000_0000);
      axi(1'b0, 12'h0FC, 0, 1'b1, `RPU_RESP_SLV, 32'h0000_0000);
      axi(1'b0, 12'h120, 0, 1'b1, `RPU_RESP_SLV, 32'h0000_0000);
      acc(32'h0000_0040, RPU_OP_WRITE, RPU_LVL_USER, 1'b1);
   endtask
   task t_cfg_guard;
      axi(1'b1, `RPU_OFF_RATTR, 32'h0000_000D, 1'b0, `RPU_RESP_SLV, 0);
      axi(1'b0, `RPU_OFF_RATTR, 0, 1'b1, `RPU_RESP_OK, 32'h0000_0000);
   endtask
   task t_perm_table;
      logic [2:0] apc [6];
      logic [3:0] msk [6];
      logic [31:0] a;
      apc = '{`RPU_AP_NONE, `RPU_AP_PRW, `RPU_AP_PRW_URO, `RPU_AP_FULL, `RPU_AP_PRO, `RPU_AP_RO};
      msk = '{4'b0000, 4'b1100, 4'b1110, 4'b1111, 4'b1000, 4'b1010};
      for (int i = 0; i < 6; i++) region(i, 256 * i, 256 * i + 255, {apc[i], 2'b01});
      axi(1'b1, `RPU_OFF_CTRL, 32'h0000_0001, 1'b1, `RPU_RESP_OK, 0);
      for (int i = 0; i < 6; i++) begin
         a = 32'(260 * i);
         acc(a, RPU_OP_READ, RPU_LVL_PRIV, msk[i][3]);
         acc(a, RPU_OP_WRITE, RPU_LVL_PRIV, msk[i][2]);
         acc(a, RPU_OP_READ, RPU_LVL_USER, msk[i][1]);
         acc(a, RPU_OP_WRITE, RPU_LVL_USER, msk[i][0]);
      end
      acc(32'h0000_0104, RPU_OP_READ, RPU_LVL_PRIV, 1'b1);
   endtask
   task t_exec;
      region(6, 32'h0000_0600, 32'h0000_06FF, {`RPU_AP_FULL, 2'b11});
      acc(32'h0000_0600, RPU_OP_EXEC, RPU_LVL_PRIV, 1'b0);
      acc(32'h0000_0608, RPU_OP_READ, RPU_LVL_USER, 1'b1);
      acc(32'h0000_030C, RPU_OP_EXEC, RPU_LVL_USER, 1'b1);
   endtask
   task t_overlap;
      region(7, 32'h0000_0000, 32'h0000_00FF, {`RPU_AP_FULL, 2'b01});
      acc(32'h0000_0010, RPU_OP_WRITE, RPU_LVL_USER, 1'b1);
      acc(32'h0000_0010, RPU_OP_READ, RPU_LVL_USER, 1'b1);
   endtask
   task t_background;
      acc(32'h0000_8008, RPU_OP_READ, RPU_LVL_PRIV, 1'b1);
      acc(32'h0000_8008, RPU_OP_READ, RPU_LVL_USER, 1'b0);
      #1;
      ck("core_fault_addr", 32'h0000_8008, core_fault_addr);
      ck("core_fault_op", {30'd0, RPU_OP_READ}, {30'd0, core_fault_op});
      axi(1'b0, `RPU_OFF_FADDR, 0, 1'b1, `RPU_RESP_OK, 32'h0000_8008);
      axi(1'b0, `RPU_OFF_FSTAT, 0, 1'b1, `RPU_RESP_OK, 32'h0000_0001);
      axi(1'b1, `RPU_OFF_FSTAT, 32'h0000_0001, 1'b1, `RPU_RESP_OK, 0);
      axi(1'b0, `RPU_OFF_FSTAT, 0, 1'b1, `RPU_RESP_OK, 32'h0000_0000);
   endtask
   // ==========
   // main sequence
   initial begin
      foreach (sh[i]) sh[i] = 32'h0000_0000;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      {core_req, core_addr, core_wdata} = '0;
      core_op = RPU_OP_READ;
      core_lvl = RPU_LVL_USER;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_defaults();
      t_cfg_guard();
      t_perm_table();
      t_exec();
      t_overlap();
      t_background();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
